// File: verilog/sawp_top.v
// Status register guard and array range protection behind an APB slave.
// Notes on behaviour
// - Two guard mode bits kept at S8, S7.
// - Mode 00: pin ignored, latch alone permits.
// - Mode 01 with pin low: refuse writes; with quad lines on, the code ignores the pin and the latch alone permits.
// - Mode 01 with pin high: latch permits.
// - Mode 10: refuse until power cycle.
// - Power cycle returns guard bits to 00.
// - Mode 11: status writes always refused.
// - Quad enable bit at S9, default zero.
// - Invert bit at S14, default zero.
// - Invert bit flips the selected protection.
// - Pause flag S15 set by pause command.
// - Resume command or power cycle clears pause.
// - Size 000 protects none, 111 all.
// - Block, top: 128 kB to 4 MB upward.
// - Block, bottom: 128 kB to 4 MB low.
// - Sector, top: 4 kB to 32 kB.
// - Sector, bottom: 4 kB to 32 kB.
// - Inverted block: complement of plain range.
// - Inverted sector: all except sector range.
// - Refuse erase or program touching protection.
// - One inverted sector setting bypasses refusal.
// - Size bits at S4..S2, default zero.
// - Low-end bit and small-unit bit select.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "sawp_defs.vh"

module sawp_top #(
  // When one, the known deviating setting lets commands through.
  parameter DEVIATION_PASS = 1'b1
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        arst_n,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Write-protect pin, active low, asynchronous to clk.
  input  wire        wp_n_pin,
  // Block outputs.
  output reg         quad_lines_enable,
  output reg         array_op_go,
  output reg         status_wr_done
);

  // ****************************************
  // Status bits
  // ****************************************
  reg        status_guard_mode_hi; // Upper guard mode bit.
  reg        status_guard_mode_lo; // Lower guard mode bit.
  reg        invert_protection;    // Complement of the range.
  reg        small_unit_select;    // Sectors when one.
  reg        from_low_end;         // Bottom of array when one.
  reg  [2:0] range_size;           // Range size code.
  reg        write_permit_latch;   // Set by write enable.
  reg        erase_pause_flag;     // Set while suspended.

  // Command operands and outcome.
  reg [23:0] op_start;             // First addressed byte.
  reg [23:0] op_last;              // Last byte of a program.
  reg  [4:0] result;               // Outcome of last command.

  // Pin synchroniser stages.
  reg        wp_meta;              // First stage, read only by wp_sync.
  reg        wp_sync;              // Second stage.

  // ****************************************
  // Write-protect pin synchroniser
  // ****************************************
  // The pin is not related to clk, so it passes two flops first.
  // Both stages reset high, the unguarded level, so no false low
  // is seen while reset lets go.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= wp_n_pin;
      wp_sync <= wp_meta;
    end
  end

  // A pin change takes two clocks to be seen, so a host must let it
  // settle before it issues a status write.
  // With quad lines on, the pin carries data and guards nothing.
  wire wp_level = quad_lines_enable | wp_sync;

  // ****************************************
  // Status image
  // ****************************************
  wire [15:0] status_image;   // Read view of all status bits.
  // Reserved bits 13 to 10 and bit 0 read zero; no busy state here.
  assign status_image = {erase_pause_flag, invert_protection, 4'h0,
                         quad_lines_enable, status_guard_mode_hi,
                         status_guard_mode_lo, small_unit_select,
                         from_low_end, range_size,
                         write_permit_latch, 1'b0};

  // ****************************************
  // Protected range decode
  // ****************************************
  reg [23:0] span;       // Size of the plain range in bytes.
  reg [23:0] base_lo;    // Plain range first byte.
  reg [23:0] base_hi;    // Plain range last byte.
  reg        base_none;  // Plain range is empty.
  reg        base_all;   // Plain range is the whole array.
  reg [23:0] prot_lo;    // Final protected first byte.
  reg [23:0] prot_hi;    // Final protected last byte.
  reg        prot_none;  // Nothing is protected.

  // The range is rebuilt from the live bits, so any status write
  // applies to the very next command with no stale copy.
  always @* begin
    span = `SAWP_SEC_UNIT;
    if (small_unit_select) begin
      case (range_size)
        3'd1: span = `SAWP_SEC_UNIT;
        3'd2: span = `SAWP_SEC_UNIT << 1;
        3'd3: span = `SAWP_SEC_UNIT << 2;
        // Codes 100 and 101 give 32 kB; 110 is taken the same way.
        default: span = `SAWP_SEC_UNIT << 3;
      endcase
    end else begin
      // Code 000 wraps the shift to zero; the empty case masks it.
      // Each code step doubles the block range.
      span = `SAWP_BLK_UNIT << (range_size - 3'd1);
    end
    // Low-end bit picks the bottom, else the top.
    if (from_low_end) begin
      base_lo = 24'h000000;
      base_hi = span - 24'h000001;
    end else begin
      base_lo = `SAWP_ARRAY_SIZE - span;
      base_hi = `SAWP_ARRAY_END;
    end
    base_none = (range_size == 3'd0);
    base_all  = (range_size == 3'd7);
    // An empty range reads back as zero bounds, like the inverted
    // whole-array case, so software sees one clean idle value.
    if (base_none) begin
      base_lo = 24'h000000;
      base_hi = 24'h000000;
    end
    if (base_all) begin
      base_lo = 24'h000000;
      base_hi = `SAWP_ARRAY_END;
    end
    // The complement of a range at one end is one range at the
    // other end, so a single pair of bounds always suffices.
    // Inverting an empty range protects all; inverting all protects none.
    if (!invert_protection) begin
      prot_none = base_none;
      prot_lo   = base_lo;
      prot_hi   = base_hi;
    end else if (base_none) begin
      prot_none = 1'b0;
      prot_lo   = 24'h000000;
      prot_hi   = `SAWP_ARRAY_END;
    end else if (base_all) begin
      prot_none = 1'b1;
      prot_lo   = 24'h000000;
      prot_hi   = 24'h000000;
    end else if (from_low_end) begin
      prot_none = 1'b0;
      prot_lo   = base_hi + 24'h000001;
      prot_hi   = `SAWP_ARRAY_END;
    end else begin
      prot_none = 1'b0;
      prot_lo   = 24'h000000;
      prot_hi   = base_lo - 24'h000001;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  // Writes land only at the completing edge of the access phase.
  // Status, result and range registers ignore writes, with no error.
  wire       access  = psel & penable & pready;  // Completing edge.
  wire [7:0] cmd_op  = pwdata[7:0];              // Command code.
  wire       cmd_wr  = access & pwrite & (paddr == `SAWP_OFS_CMD);
  wire       addr_wr = access & pwrite & (paddr == `SAWP_OFS_ADDR);
  wire       end_wr  = access & pwrite & (paddr == `SAWP_OFS_END);

  reg        addr_hit; // Address is mapped.
  reg [31:0] rd_mux;   // Read data for the addressed register.

  // Read mux; unmapped addresses read zero and raise pslverr.
  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h00000000;
    case (paddr)
      `SAWP_OFS_STATUS:  rd_mux = {16'h0000, status_image};
      // The command register is a strobe, not storage, so it reads zero.
      `SAWP_OFS_CMD:     rd_mux = 32'h00000000;
      `SAWP_OFS_ADDR:    rd_mux = {8'h00, op_start};
      `SAWP_OFS_END:     rd_mux = {8'h00, op_last};
      `SAWP_OFS_RESULT:  rd_mux = {27'h0000000, result};
      `SAWP_OFS_PROT_LO: rd_mux = {prot_none, 7'h00, prot_lo};
      `SAWP_OFS_PROT_HI: rd_mux = {8'h00, prot_hi};
      default:           addr_hit = 1'b0;
    endcase
  end

  // One-cycle answer: pready rises in the access phase and drops
  // after the completing edge, so back-to-back transfers work.
  // Read data is captured at the setup edge, so the live range words
  // show the bits as they stood one cycle before completion.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel & ~penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~addr_hit;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Array command region
  // ****************************************
  reg [23:0] reg_lo;  // First byte the command touches.
  reg [23:0] reg_hi;  // Last byte the command touches.
  reg        is_arr;  // Command is erase or program.

  // Erases cover their aligned unit; a program covers start..last.
  // The region is decoded from the live command code on the bus.
  always @* begin
    is_arr = 1'b1;
    reg_lo = op_start;
    reg_hi = op_start;
    case (cmd_op)
      // A last byte below the start is taken as a one-byte program.
      `SAWP_OP_PROG: begin
        reg_hi = (op_last < op_start) ? op_start : op_last;
      end
      `SAWP_OP_ER4K: begin
        reg_lo = op_start & ~`SAWP_MASK_4K;
        reg_hi = op_start | `SAWP_MASK_4K;
      end
      `SAWP_OP_ER32K: begin
        reg_lo = op_start & ~`SAWP_MASK_32K;
        reg_hi = op_start | `SAWP_MASK_32K;
      end
      `SAWP_OP_ER64K: begin
        reg_lo = op_start & ~`SAWP_MASK_64K;
        reg_hi = op_start | `SAWP_MASK_64K;
      end
      // Chip erase spans the whole array, so any protection refuses it, except the passed inverted bottom 4 kB setting.
      `SAWP_OP_CHIP_A, `SAWP_OP_CHIP_B: begin
        reg_lo = 24'h000000;
        reg_hi = `SAWP_ARRAY_END;
      end
      default: is_arr = 1'b0;
    endcase
  end

  // Any overlap blocks: both ends are checked against the range.
  wire overlap = ~prot_none & (reg_lo <= prot_hi) &
                 (reg_hi >= prot_lo);
  // The one inverted bottom 4 kB setting is let through.
  wire deviant = invert_protection & small_unit_select &
                 from_low_end & (range_size == 3'd1);
  // Trade-off: the pass is a parameter, so a build can choose strict
  // refusal for that setting instead.
  wire blocked = overlap & ~(DEVIATION_PASS & deviant);
  wire arr_ok  = write_permit_latch & ~blocked;

  // ****************************************
  // Status write guard
  // ****************************************
  reg guard_ok; // Status write allowed now.

  // The mode pair picks the guard; locked modes ignore latch and pin.

  always @* begin
    case ({status_guard_mode_hi, status_guard_mode_lo})
      2'b00: guard_ok = write_permit_latch;
      2'b01: guard_ok = wp_level & write_permit_latch;
      2'b10: guard_ok = 1'b0;
      default: guard_ok = 1'b0;
    endcase
  end

  // The status data rides in the upper half of the command word.
  wire [15:0] new_sr = pwdata[31:16]; // Status data of a write.

  // ****************************************
  // Command execution and status state
  // ****************************************
  // Reset stands for the power cycle: every bit returns to its
  // default, which also ends lock-down. A one-time-program setting
  // cannot outlive reset here because no storage survives power.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_guard_mode_hi <= 1'b0;
      status_guard_mode_lo <= 1'b0;
      quad_lines_enable    <= 1'b0;
      invert_protection    <= 1'b0;
      small_unit_select    <= 1'b0;
      from_low_end         <= 1'b0;
      range_size           <= 3'd0;
      write_permit_latch   <= 1'b0;
      erase_pause_flag     <= 1'b0;
      // Operands clear too, so a stale address never reaches a command.
      op_start             <= 24'h000000;
      op_last              <= 24'h000000;
      result               <= 5'h00;
      array_op_go          <= 1'b0;
      status_wr_done       <= 1'b0;
    end else begin
      array_op_go    <= 1'b0;
      status_wr_done <= 1'b0;
      if (addr_wr) begin
        op_start <= pwdata[23:0];
      end
      if (end_wr) begin
        op_last <= pwdata[23:0];
      end
      if (cmd_wr) begin
        // Each command clears the outcome, so it shows only the last one.
        result <= 5'h00;
        if (cmd_op == `SAWP_OP_WREN) begin
          write_permit_latch <= 1'b1;
        end else if (cmd_op == `SAWP_OP_WRDIS) begin
          write_permit_latch <= 1'b0;
        end else if (cmd_op == `SAWP_OP_PAUSE) begin
          erase_pause_flag <= 1'b1;
        end else if (cmd_op == `SAWP_OP_RESUME) begin
          erase_pause_flag <= 1'b0;
        end else if (cmd_op == `SAWP_OP_WRSTAT) begin
          if (guard_ok) begin
            // Read-only bits S15, S1, S0 are not loaded from the data; S1 is cleared below.
            status_guard_mode_hi <= new_sr[`SAWP_POS_GUARDHI];
            status_guard_mode_lo <= new_sr[`SAWP_POS_GUARDLO];
            quad_lines_enable    <= new_sr[`SAWP_POS_QUAD];
            invert_protection    <= new_sr[`SAWP_POS_INVERT];
            small_unit_select    <= new_sr[`SAWP_POS_SMALL];
            from_low_end         <= new_sr[`SAWP_POS_LOWEND];
            range_size <= new_sr[`SAWP_POS_RSIZE+2:`SAWP_POS_RSIZE];
            // An accepted write consumes the latch.
            write_permit_latch   <= 1'b0;
            status_wr_done       <= 1'b1;
            result[3]            <= 1'b1;
          end else begin
            result[4] <= 1'b1;
          end
        end else if (is_arr) begin
          if (arr_ok) begin
            array_op_go        <= 1'b1;
            write_permit_latch <= 1'b0;
            result[0]          <= 1'b1;
          // A refused operation keeps the latch so the host may retry.
          end else if (!write_permit_latch) begin
            result[2] <= 1'b1;
          end else begin
            result[1] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // sawp_top

// File: verilog/sawp_defs.vh
// Constants for the status and array write-protect block.
`ifndef SAWP_DEFS_VH
`define SAWP_DEFS_VH

// ****************************************
// Register byte offsets on the APB side
// ****************************************
`define SAWP_OFS_STATUS  12'h000
`define SAWP_OFS_CMD     12'h004
`define SAWP_OFS_ADDR    12'h008
`define SAWP_OFS_END     12'h00C
`define SAWP_OFS_RESULT  12'h010
`define SAWP_OFS_PROT_LO 12'h014
`define SAWP_OFS_PROT_HI 12'h018

// ****************************************
// Status image bit positions
// ****************************************
`define SAWP_POS_PAUSE   15
`define SAWP_POS_INVERT  14
`define SAWP_POS_QUAD    9
`define SAWP_POS_GUARDHI 8
`define SAWP_POS_GUARDLO 7
`define SAWP_POS_SMALL   6
`define SAWP_POS_LOWEND  5
`define SAWP_POS_RSIZE   2
`define SAWP_POS_LATCH   1
`define SAWP_STATUS_RST  16'h0000

// ****************************************
// Command codes in the low byte of CMD
// ****************************************
`define SAWP_OP_WREN     8'h06
`define SAWP_OP_WRDIS    8'h04
`define SAWP_OP_WRSTAT   8'h01
`define SAWP_OP_PAUSE    8'h75
`define SAWP_OP_RESUME   8'h7A
`define SAWP_OP_PROG     8'h02
`define SAWP_OP_ER4K     8'h20
`define SAWP_OP_ER32K    8'h52
`define SAWP_OP_ER64K    8'hD8
`define SAWP_OP_CHIP_A   8'h60
`define SAWP_OP_CHIP_B   8'hC7

// ****************************************
// Array geometry
// ****************************************
`define SAWP_ARRAY_END   24'h7FFFFF
`define SAWP_ARRAY_SIZE  24'h800000
`define SAWP_BLK_UNIT    24'h020000
`define SAWP_SEC_UNIT    24'h001000
`define SAWP_MASK_4K     24'h000FFF
`define SAWP_MASK_32K    24'h007FFF
`define SAWP_MASK_64K    24'h00FFFF

`endif

// File: test/sawp_properties.sv
// Assertion checker for the status and array write-protect block.
`timescale 1ns/1ps
`include "sawp_defs.vh"

module sawp_properties (
  // Clock and reset.
  input wire        clk,
  input wire        arst_n,
  // APB side.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pin and block outputs.
  input wire        wp_n_pin,
  input wire        quad_lines_enable,
  input wire        array_op_go,
  input wire        status_wr_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A setup cycle, and the completing edge of a command write.
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence cmd_done_s;
    psel && penable && pready && pwrite && paddr == `SAWP_OFS_CMD;
  endsequence
  ready_in_one_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  go_pulse_a: assert property (array_op_go |=> !array_op_go)
    else $error("array go longer than one cycle");
  ops_apart_a: assert property (cmd_done_s |=> !(array_op_go && status_wr_done))
    else $error("array go and status done together");
  idle_quiet_a: assert property (!(psel && penable && pwrite) |=> !array_op_go && !status_wr_done)
    else $error("pulse without a command write");
  wr_cause_a: assert property (status_wr_done |->
      $past(pwdata[7:0]) == `SAWP_OP_WRSTAT && $past(paddr) == `SAWP_OFS_CMD)
    else $error("status done without status write");
  quad_change_a: assert property (quad_lines_enable != $past(quad_lines_enable)
      |-> status_wr_done)
    else $error("quad enable moved without status write");
endmodule // sawp_properties

// File: test/sawp_apb_host.sv
// APB host model that stands in for the serial host.
`timescale 1ns/1ps

module sawp_apb_host (
  // Clock and reset.
  input  wire        clk,
  input  wire        arst_n,
  // Request from the bench.
  input  wire        go,
  input  wire        wr,
  input  wire [11:0] a,
  input  wire [31:0] d,
  // APB answer.
  input  wire        pready,
  input  wire [31:0] prdata,
  input  wire        pslverr,
  // APB request.
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  // Result to the bench.
  output reg         done,
  output reg  [31:0] rdata,
  output reg         err
);
  // Holds the request until pready, then releases it; write data is scrambled
  // on release so nothing relies on a stale bus.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psel <= 1'b0;
      penable <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (go) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
      end
    end
  end
endmodule // sawp_apb_host

// File: test/tb_top.sv
// Self-checking bench for the status and array write-protect block.
`timescale 1ns/1ps
`include "sawp_defs.vh"

module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wp_n_pin = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [11:0] a = 12'h000;
  logic [31:0] d = 32'h0;
  wire         psel, penable, pwrite, pready, pslverr, done, err;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata, rd;
  wire         quad_lines_enable, array_op_go, status_wr_done;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_go = 0;
  int          n_wr = 0;

  always #2.5 clk = ~clk;
  // Counts accepted array operations.
  always @(posedge clk) if (array_op_go === 1'b1) n_go <= n_go + 1;
  // Counts accepted status writes.
  always @(posedge clk) if (status_wr_done === 1'b1) n_wr <= n_wr + 1;

  sawp_top uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wp_n_pin(wp_n_pin), .quad_lines_enable(quad_lines_enable),
    .array_op_go(array_op_go), .status_wr_done(status_wr_done));
  sawp_apb_host host (.clk(clk), .arst_n(arst_n), .go(go), .wr(wr), .a(a), .d(d),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done), .rdata(rd), .err(err));

  task close_out;
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rst;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // One APB transfer through the host model, bounded wait.
  task xfer(input logic w, input logic [11:0] ad, input logic [31:0] dt);
    int k;
    wr <= w; a <= ad; d <= dt; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 20 && !done; k++) @(posedge clk);
    if (!done) begin n_mismatch++; close_out; end
    @(posedge clk);
  endtask
  task cmd(input logic [7:0] c, input logic [15:0] v);
    xfer(1'b1, `SAWP_OFS_CMD, {v, 8'h00, c});
  endtask
  task wstat(input logic [15:0] v);
    cmd(`SAWP_OP_WREN, 16'h0);
    cmd(`SAWP_OP_WRSTAT, v);
  endtask
  task st(input logic [31:0] exp);
    xfer(1'b0, `SAWP_OFS_STATUS, 32'h0);
    chk(rd, exp);
  endtask
  task rng(input logic [15:0] s, input logic [31:0] lo, input logic [23:0] hi);
    int w;
    w = n_wr;
    wstat(s);
    chk(n_wr - w, 32'h1);
    xfer(1'b0, `SAWP_OFS_PROT_LO, 32'h0);
    chk({rd[31], 7'h0, rd[23:0]}, lo);
    xfer(1'b0, `SAWP_OFS_PROT_HI, 32'h0);
    chk({8'h0, rd[23:0]}, {8'h0, hi});
  endtask
  task aop(input logic [7:0] op, input logic [23:0] s, input logic [23:0] e,
           input logic we, input logic [31:0] res);
    int g;
    xfer(1'b1, `SAWP_OFS_ADDR, {8'h00, s});
    xfer(1'b1, `SAWP_OFS_END, {8'h00, e});
    if (we) cmd(`SAWP_OP_WREN, 16'h0);
    else cmd(`SAWP_OP_WRDIS, 16'h0);
    g = n_go;
    cmd(op, 16'h0);
    xfer(1'b0, `SAWP_OFS_RESULT, 32'h0);
    chk(rd, res);
    chk(n_go - g, {31'h0, res[0]});
  endtask

  // Defaults after reset and an unmapped read.
  task t_reset_vals;
    st(32'h0);
    xfer(1'b0, `SAWP_OFS_PROT_LO, 32'h0);
    chk({rd[31], 7'h0, rd[23:0]}, 32'h80000000);
    xfer(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task t_pause;
    cmd(`SAWP_OP_PAUSE, 16'h0);
    st(32'h8000);
    cmd(`SAWP_OP_RESUME, 16'h0);
    st(32'h0);
    cmd(`SAWP_OP_PAUSE, 16'h0);
    rst;
    st(32'h0);
  endtask
  // Walks every guard mode; modes 00 and 01 with the pin low and high, 10 and 11 with it high.
  task t_guard;
    cmd(`SAWP_OP_WRSTAT, 16'h0080);
    st(32'h0);
    wstat(16'h0080);
    st(32'h0080);
    wstat(16'h0000);
    st(32'h0082);
    wp_n_pin <= 1'b1;
    wstat(16'h0100);
    st(32'h0100);
    wstat(16'h0000);
    st(32'h0102);
    rst;
    st(32'h0);
    wstat(16'h0180);
    wstat(16'h0000);
    st(32'h0182);
    rst;
    wstat(16'h0200); // pin is driven, never tied
    chk({31'h0, quad_lines_enable}, 32'h1);
    wstat(16'h0280); // quad on, hardware guard mode
    wp_n_pin <= 1'b0;
    wstat(16'h0200);
    st(32'h0200); // pin low is a data line, no guard
    rst;
  endtask
  task t_ranges;
    rng(16'h0000, 32'h80000000, 24'h0);
    rng(16'h001C, 32'h0, 24'h7FFFFF);
    rng(16'h0004, 32'h7E0000, 24'h7FFFFF);
    rng(16'h0018, 32'h400000, 24'h7FFFFF);
    rng(16'h0024, 32'h0, 24'h01FFFF);
    rng(16'h0038, 32'h0, 24'h3FFFFF);
    rng(16'h0044, 32'h7FF000, 24'h7FFFFF);
    rng(16'h0054, 32'h7F8000, 24'h7FFFFF);
    rng(16'h0068, 32'h0, 24'h001FFF);
    rng(16'h0070, 32'h0, 24'h007FFF);
    rng(16'h4004, 32'h0, 24'h7DFFFF);
    rng(16'h4000, 32'h0, 24'h7FFFFF);
    rng(16'h401C, 32'h80000000, 24'h0);
    rng(16'h4044, 32'h0, 24'h7FEFFF);
    rng(16'h4070, 32'h008000, 24'h7FFFFF);
  endtask
  task t_array;
    rst;
    wstat(16'h0004);
    aop(`SAWP_OP_PROG, 24'h7DFF00, 24'h7E0000, 1'b1, 32'h2);
    aop(`SAWP_OP_PROG, 24'h7DFF00, 24'h7DFFFF, 1'b1, 32'h1);
    aop(`SAWP_OP_ER4K, 24'h7E0000, 24'h0, 1'b1, 32'h2);
    aop(`SAWP_OP_ER64K, 24'h7D0000, 24'h0, 1'b1, 32'h1);
    aop(`SAWP_OP_ER32K, 24'h7F8000, 24'h0, 1'b1, 32'h2);
    aop(`SAWP_OP_CHIP_A, 24'h0, 24'h0, 1'b1, 32'h2);
    aop(`SAWP_OP_CHIP_B, 24'h0, 24'h0, 1'b1, 32'h2);
    aop(`SAWP_OP_PROG, 24'h0, 24'h0, 1'b0, 32'h4);
    wstat(16'h4068);
    aop(`SAWP_OP_PROG, 24'h002000, 24'h0020FF, 1'b1, 32'h2);
    wstat(16'h4064);
    aop(`SAWP_OP_PROG, 24'h002000, 24'h0020FF, 1'b1, 32'h1);
  endtask

  initial begin
    rst;
    t_reset_vals;
    t_pause;
    t_guard;
    t_ranges;
    t_array;
    close_out;
  end
endmodule // tb_top

bind sawp_top sawp_properties u_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wp_n_pin(wp_n_pin),
  .quad_lines_enable(quad_lines_enable), .array_op_go(array_op_go),
  .status_wr_done(status_wr_done));
